// >>> hw/nvg_pkg.sv
// Package: register map, fields and timing of the data EEPROM write guard
package nvg_pkg;
  // Register byte addresses
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_UNLOCK    = 8'h04;
  localparam logic [7:0] OFS_ADDR_LO   = 8'h08;
  localparam logic [7:0] OFS_ADDR_HI   = 8'h0C;
  localparam logic [7:0] OFS_DATA_LO   = 8'h10;
  localparam logic [7:0] OFS_DATA_HI   = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h18;
  localparam logic [7:0] OFS_IRQ_FLAG  = 8'h1C;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h20;
  // Control field positions
  localparam int CTL_RD     = 0;
  localparam int CTL_WR     = 1;
  localparam int CTL_PERMIT = 2;
  localparam int CTL_FAULT  = 3;
  localparam int CTL_ARRAY  = 7;
  // Done flag / enable position in the second flag register
  localparam int IRQ_DONE   = 4;
  // Implemented bit masks
  localparam logic [7:0] MASK_CONTROL = 8'h8F;
  localparam logic [7:0] MASK_ADDR_HI = 8'h1F;
  localparam logic [7:0] MASK_DATA_HI = 8'h3F;
  localparam logic [7:0] MASK_IRQ     = 8'hFD;
  // Reset values
  localparam logic [7:0] RST_REG8 = 8'h00;
  // Unlock keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // Timing
  localparam longint CLK_HZ         = 50000000;
  localparam longint PWRT_MS        = 64;
  localparam longint PWRT_CYCLES    = (PWRT_MS * CLK_HZ) / 1000;
  localparam int     WRITE_CYCLES   = 16;
  typedef enum logic [1:0] {US_IDLE, US_FIRST, US_ARMED} nvg_unlock_type;
endpackage : nvg_pkg

// >>> hw/nvg_pwrt.sv
// Power-up timer: holds writes off for a fixed count after reset
`timescale 1ns/1ns
module nvg_pwrt #(
  parameter int unsigned COUNT = 32'(nvg_pkg::PWRT_CYCLES)
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Status
  output      logic running
);
  logic [31:0] cnt_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r   <= 32'h0000_0000;
      running <= 1'b1;
    end else if (cnt_r < COUNT - 1) begin
      cnt_r   <= cnt_r + 32'h0000_0001;
      running <= 1'b1;
    end else begin
      running <= 1'b0;
    end
  end

  property p_count_min;
    @(posedge ref_clk) disable iff (rst) !running |-> (cnt_r >= COUNT - 1);
  endproperty
  a_count_min: assert property (p_count_min) else $error("timer ended early");
endmodule : nvg_pwrt

// >>> hw/nvg_array.sv
// Byte-wide data EEPROM storage array
`timescale 1ns/1ns
module nvg_array #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  // Clock
  input  wire logic          ref_clk,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output      logic [7:0]    rdata
);
  logic [7:0] mem [DEPTH];

  // Contents survive reset, as nonvolatile storage would
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : nvg_array

// >>> hw/nvg_guard.sv
// Data EEPROM access and write-protection logic with APB register slave
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module nvg_guard #(
  parameter int          AW          = 8,
  parameter int unsigned PWRT_COUNT  = 32'(nvg_pkg::PWRT_CYCLES),
  parameter int          WRITE_COUNT = nvg_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // Configuration and external programmer
  input  wire logic        data_protect_config,
  input  wire logic        ext_rd_req,
  input  wire logic [7:0]  ext_addr,
  output      logic [7:0]  ext_rdata,
  output      logic        ext_refused,
  // Interrupt
  output      logic        irq
);
  logic        pwrt_running;
  logic [7:0]  ctl_r;
  logic [7:0]  addr_lo_r;
  logic [7:0]  addr_hi_r;
  logic [7:0]  data_lo_r;
  logic [7:0]  data_hi_r;
  logic [7:0]  irq_en_r;
  logic [7:0]  irq_flag_r;
  logic [7:0]  arr_rdata;
  logic [7:0]  arr_raddr;
  logic        arr_we;
  logic        busy_r;
  logic [15:0] wcnt_r;
  logic        rd_pend_r;
  logic        done_pulse;
  nvg_pkg::nvg_unlock_type ustate_r;

  wire logic wr_acc = psel && penable && pwrite;
  wire logic rd_acc = psel && penable && !pwrite;
  wire logic key_wr = wr_acc && hit(paddr, nvg_pkg::OFS_UNLOCK);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Upper word bits and unimplemented bits read as zero
  function automatic logic [31:0] rd8(input logic [7:0] v, input logic [7:0] msk);
    rd8 = {24'h000000, v & msk};
  endfunction : rd8

  nvg_pwrt #(.COUNT(PWRT_COUNT)) u_pwrt (
    .ref_clk (ref_clk),
    .rst     (rst),
    .running (pwrt_running)
  );

  // Unlock sequencer: any other bus access in between breaks it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ustate_r <= nvg_pkg::US_IDLE;
    end else if (psel && penable) begin
      case (ustate_r)
        nvg_pkg::US_IDLE: begin
          if (key_wr && pwdata[7:0] == nvg_pkg::KEY_FIRST) begin
            ustate_r <= nvg_pkg::US_FIRST;
          end
        end
        nvg_pkg::US_FIRST: begin
          if (key_wr && pwdata[7:0] == nvg_pkg::KEY_SECOND) begin
            ustate_r <= nvg_pkg::US_ARMED;
          end else begin
            ustate_r <= nvg_pkg::US_IDLE;
          end
        end
        nvg_pkg::US_ARMED: ustate_r <= nvg_pkg::US_IDLE;
        default:           ustate_r <= nvg_pkg::US_IDLE;
      endcase
    end
  end

  // Write start is honoured only with permit, unlock and timer done
  wire logic wr_req   = wr_acc && hit(paddr, nvg_pkg::OFS_CONTROL) && pwdata[nvg_pkg::CTL_WR];
  wire logic wr_start = wr_req && !busy_r && ustate_r == nvg_pkg::US_ARMED
                        && ctl_r[nvg_pkg::CTL_PERMIT] && !pwrt_running;

  // Write timer standing in for the array's programming time
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      wcnt_r <= 16'h0000;
    end else if (wr_start) begin
      busy_r <= 1'b1;
      wcnt_r <= 16'(WRITE_COUNT - 1);
    end else if (busy_r) begin
      if (wcnt_r == 16'h0000) begin
        busy_r <= 1'b0;
      end else begin
        wcnt_r <= wcnt_r - 16'h0001;
      end
    end
  end
  assign done_pulse = busy_r && wcnt_r == 16'h0000;
  // Commit at the end so an interrupted cycle never half-writes
  assign arr_we     = done_pulse;

  // Control register: reset clears permit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctl_r <= nvg_pkg::RST_REG8;
    end else begin
      if (wr_acc && hit(paddr, nvg_pkg::OFS_CONTROL)) begin
        ctl_r[nvg_pkg::CTL_PERMIT] <= pwdata[nvg_pkg::CTL_PERMIT];
        ctl_r[nvg_pkg::CTL_ARRAY]  <= pwdata[nvg_pkg::CTL_ARRAY];
        if (!pwdata[nvg_pkg::CTL_FAULT]) begin
          ctl_r[nvg_pkg::CTL_FAULT] <= 1'b0;
        end
        if (pwdata[nvg_pkg::CTL_RD] && !busy_r) begin
          ctl_r[nvg_pkg::CTL_RD] <= 1'b1;
        end
      end
      if (rd_pend_r) begin
        ctl_r[nvg_pkg::CTL_RD] <= 1'b0;
      end
      ctl_r[nvg_pkg::CTL_WR] <= wr_start || (busy_r && !done_pulse);
      // Attempted start without unlock or permit is flagged
      if (wr_req && !wr_start) begin
        ctl_r[nvg_pkg::CTL_FAULT] <= 1'b1;
      end
    end
  end

  // Address and data registers; read result lands in the data register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addr_lo_r <= nvg_pkg::RST_REG8;
      addr_hi_r <= nvg_pkg::RST_REG8;
      data_lo_r <= nvg_pkg::RST_REG8;
      data_hi_r <= nvg_pkg::RST_REG8;
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= wr_acc && hit(paddr, nvg_pkg::OFS_CONTROL)
                   && pwdata[nvg_pkg::CTL_RD] && !busy_r;
      if (wr_acc && hit(paddr, nvg_pkg::OFS_ADDR_LO)) begin
        addr_lo_r <= pwdata[7:0];
      end
      if (wr_acc && hit(paddr, nvg_pkg::OFS_ADDR_HI)) begin
        addr_hi_r <= pwdata[7:0] & nvg_pkg::MASK_ADDR_HI;
      end
      if (wr_acc && hit(paddr, nvg_pkg::OFS_DATA_HI)) begin
        data_hi_r <= pwdata[7:0] & nvg_pkg::MASK_DATA_HI;
      end
      if (rd_pend_r) begin
        data_lo_r <= arr_rdata;
      end else if (wr_acc && hit(paddr, nvg_pkg::OFS_DATA_LO)) begin
        data_lo_r <= pwdata[7:0];
      end
    end
  end

  // Array read port shared with the programmer, CPU has priority
  wire logic ext_ok = data_protect_config && !rd_pend_r;
  wire logic cpu_rd = wr_acc && hit(paddr, nvg_pkg::OFS_CONTROL);
  // A protected programmer never reaches the array; the CPU always does
  assign arr_raddr = (ext_rd_req && data_protect_config && !cpu_rd) ?
                     ext_addr : addr_lo_r;

  nvg_array #(.DEPTH(1 << AW), .AW(AW)) u_array (
    .ref_clk (ref_clk),
    .we      (arr_we),
    .waddr   (addr_lo_r[AW-1:0]),
    .wdata   (data_lo_r),
    .raddr   (arr_raddr[AW-1:0]),
    .rdata   (arr_rdata)
  );

  // Programmer port: refused outright while data is protected
  logic ext_pend_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_pend_r  <= 1'b0;
      ext_rdata   <= nvg_pkg::RST_REG8;
      ext_refused <= 1'b0;
    end else begin
      ext_pend_r  <= ext_rd_req && ext_ok && !(wr_acc && hit(paddr, nvg_pkg::OFS_CONTROL));
      ext_refused <= ext_rd_req && !data_protect_config;
      if (ext_pend_r) begin
        ext_rdata <= arr_rdata;
      end else if (!data_protect_config) begin
        ext_rdata <= nvg_pkg::RST_REG8;
      end
    end
  end

  // Interrupt enable, sticky flags (set wins over clear), level output
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_en_r   <= nvg_pkg::RST_REG8;
      irq_flag_r <= nvg_pkg::RST_REG8;
      irq        <= 1'b0;
    end else begin
      if (wr_acc && hit(paddr, nvg_pkg::OFS_IRQ_EN)) begin
        irq_en_r <= pwdata[7:0] & nvg_pkg::MASK_IRQ;
      end
      if (wr_acc && hit(paddr, nvg_pkg::OFS_IRQ_CLR)) begin
        irq_flag_r <= irq_flag_r & ~pwdata[7:0];
      end
      if (done_pulse) begin
        irq_flag_r[nvg_pkg::IRQ_DONE] <= 1'b1;
      end
      irq <= |(irq_flag_r & irq_en_r);
    end
  end

  // APB read mux, zero wait states
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          nvg_pkg::OFS_CONTROL:  prdata <= {24'h000000, ctl_r & nvg_pkg::MASK_CONTROL};
          nvg_pkg::OFS_UNLOCK:   prdata <= 32'h0000_0000;
          nvg_pkg::OFS_ADDR_LO:  prdata <= {24'h000000, addr_lo_r};
          nvg_pkg::OFS_ADDR_HI:  prdata <= rd8(addr_hi_r, nvg_pkg::MASK_ADDR_HI);
          nvg_pkg::OFS_DATA_LO:  prdata <= {24'h000000, data_lo_r};
          nvg_pkg::OFS_DATA_HI:  prdata <= rd8(data_hi_r, nvg_pkg::MASK_DATA_HI);
          nvg_pkg::OFS_IRQ_EN:   prdata <= {24'h000000, irq_en_r & nvg_pkg::MASK_IRQ};
          nvg_pkg::OFS_IRQ_FLAG: prdata <= {24'h000000, irq_flag_r & nvg_pkg::MASK_IRQ};
          nvg_pkg::OFS_IRQ_CLR:  prdata <= 32'h0000_0000;
          default:               pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Checks
  property p_permit_reset;
    @(posedge ref_clk) $rose(rst) |=> !ctl_r[nvg_pkg::CTL_PERMIT];
  endproperty
  a_permit_reset: assert property (p_permit_reset) else $error("permit not cleared");

  property p_pwrt_block;
    @(posedge ref_clk) disable iff (rst) pwrt_running |-> !wr_start;
  endproperty
  a_pwrt_block: assert property (p_pwrt_block) else $error("write during power-up");

  property p_need_unlock;
    @(posedge ref_clk) disable iff (rst)
      wr_start |-> ustate_r == nvg_pkg::US_ARMED && ctl_r[nvg_pkg::CTL_PERMIT];
  endproperty
  a_need_unlock: assert property (p_need_unlock) else $error("write without unlock");

  property p_no_stray_we;
    @(posedge ref_clk) disable iff (rst) arr_we |-> ctl_r[nvg_pkg::CTL_WR];
  endproperty
  a_no_stray_we: assert property (p_no_stray_we) else $error("write outside a cycle");

  property p_fault_flag;
    @(posedge ref_clk) disable iff (rst) wr_req && !wr_start |=> ctl_r[nvg_pkg::CTL_FAULT];
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("refused start not flagged");

  property p_ext_refuse;
    @(posedge ref_clk) disable iff (rst)
      ext_rd_req && !data_protect_config |=> ext_refused ##1 (ext_rdata == 8'h00);
  endproperty
  a_ext_refuse: assert property (p_ext_refuse) else $error("protected data leaked");

  property p_read_byte;
    @(posedge ref_clk) disable iff (rst) rd_pend_r |=> data_lo_r == $past(arr_rdata);
  endproperty
  a_read_byte: assert property (p_read_byte) else $error("read byte not loaded");

  property p_zero_bits;
    @(posedge ref_clk) disable iff (rst) prdata[31:8] == 24'h000000 && addr_hi_r[7:5] == 3'h0;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unimplemented bits set");

  property p_done_flag;
    @(posedge ref_clk) disable iff (rst) done_pulse |=> irq_flag_r[nvg_pkg::IRQ_DONE];
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done flag missing");

  property p_irq_gate;
    @(posedge ref_clk) disable iff (rst)
      irq_flag_r[nvg_pkg::IRQ_DONE] && irq_en_r[nvg_pkg::IRQ_DONE] |=> irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not raised");

  // Catches an interrupt that stays up after a mask or clear
  property p_irq_cause;
    @(posedge ref_clk) disable iff (rst)
      irq |-> $past(irq_flag_r[nvg_pkg::IRQ_DONE] && irq_en_r[nvg_pkg::IRQ_DONE]);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without enabled flag");
endmodule : nvg_guard

// >>> dv/tb_nvg_guard.sv
// Self-checking testbench of the data EEPROM write guard
`timescale 1ns/1ns
module tb_nvg_guard;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic        data_protect_config, ext_rd_req, ext_refused, irq;
  logic [7:0]  paddr, ext_addr, ext_rdata, mem_a, mem_d, a, d;
  logic [31:0] pwdata, prdata, rd, v;
  logic [7:0]  mofs [5];
  logic [7:0]  mmsk [5];
  int          fail_count, n_tests;

  // Short power-up hold keeps the run brief
  nvg_guard #(.PWRT_COUNT(60)) dut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .data_protect_config(data_protect_config), .ext_rd_req(ext_rd_req),
    .ext_addr(ext_addr), .ext_rdata(ext_rdata), .ext_refused(ext_refused));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] exp_reg(input logic [31:0] val, input logic [7:0] msk);
    exp_reg = {24'h0, val[7:0] & msk};
  endfunction : exp_reg

  task automatic reset_dut;
    rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
  endtask : reset_dut

  // Master never assumes the slave latency; the bound only cuts a hang
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) begin
      fail_count++;
      wrap_up();
    end
  endtask : xfer

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    xfer(1'b1, ad, wd);
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] ad, input logic [31:0] exp);
    xfer(1'b0, ad, 32'h0);
    check(nm, rd, exp);
  endtask : rdchk

  // Optional read between the keys must spoil the unlock
  task automatic store(input logic [7:0] sa, input logic [7:0] sd, input logic [7:0] k1,
                       input logic [7:0] k2, input logic [31:0] ctl, input logic spoil);
    wr(nvg_pkg::OFS_ADDR_LO, {24'h0, sa});
    wr(nvg_pkg::OFS_DATA_LO, {24'h0, sd});
    wr(nvg_pkg::OFS_CONTROL, ctl & 32'h04);
    wr(nvg_pkg::OFS_UNLOCK, {24'h0, k1});
    if (spoil) xfer(1'b0, nvg_pkg::OFS_ADDR_LO, 32'h0);
    wr(nvg_pkg::OFS_UNLOCK, {24'h0, k2});
    wr(nvg_pkg::OFS_CONTROL, ctl);
    for (int j = 0; j < 20; j++) begin
      xfer(1'b0, nvg_pkg::OFS_CONTROL, 32'h0);
      if (rd[1] === 1'b0) break;
    end
    if (rd[1] !== 1'b0) begin
      fail_count++;
      wrap_up();
    end
  endtask : store

  task automatic fetch(input logic [7:0] fa);
    wr(nvg_pkg::OFS_ADDR_LO, {24'h0, fa});
    wr(nvg_pkg::OFS_CONTROL, 32'h01);
    xfer(1'b0, nvg_pkg::OFS_DATA_LO, 32'h0);
  endtask : fetch

  task automatic ext_chk(input logic prot, input logic [7:0] exp, input logic ref_exp);
    logic rf;
    @(posedge ref_clk);
    data_protect_config <= ~prot;
    ext_rd_req <= 1'b1;
    ext_addr <= mem_a;
    @(posedge ref_clk);
    ext_rd_req <= 1'b0;
    #1 rf = ext_refused;
    @(posedge ref_clk);
    #1 rf = rf | ext_refused;
    @(posedge ref_clk);
    #1 check("ext data", {24'h0, ext_rdata}, {24'h0, exp});
    check("ext refused", {31'h0, rf}, {31'h0, ref_exp});
  endtask : ext_chk

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, ext_rd_req} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_addr = 8'h00;
    data_protect_config = 1'b1;
    fail_count = 0;
    n_tests = 0;
    mofs = '{nvg_pkg::OFS_ADDR_LO, nvg_pkg::OFS_ADDR_HI, nvg_pkg::OFS_DATA_LO,
             nvg_pkg::OFS_DATA_HI, nvg_pkg::OFS_IRQ_EN};
    mmsk = '{8'hFF, nvg_pkg::MASK_ADDR_HI, 8'hFF, nvg_pkg::MASK_DATA_HI, nvg_pkg::MASK_IRQ};
    v = $urandom(43);
    reset_dut();
    rdchk("control reset", nvg_pkg::OFS_CONTROL, 32'h0);
    foreach (mofs[i]) rdchk("reg reset", mofs[i], 32'h0);
    xfer(1'b0, 8'h24, 32'h0);
    check("unmapped err", {31'h0, er}, 32'h1);
    check("unmapped data", rd, 32'h0);
    foreach (mofs[i]) begin
      v = $urandom();
      wr(mofs[i], v);
      rdchk("masked readback", mofs[i], exp_reg(v, mmsk[i]));
    end
    wr(nvg_pkg::OFS_IRQ_FLAG, 32'hFF);
    rdchk("flag read-only", nvg_pkg::OFS_IRQ_FLAG, 32'h0);
    $display("Test registers done");
    wr(nvg_pkg::OFS_IRQ_EN, 32'h1 << nvg_pkg::IRQ_DONE);
    repeat (3) begin
      v = $urandom();
      a = v[7:0];
      d = v[15:8];
      store(a, d, nvg_pkg::KEY_FIRST, nvg_pkg::KEY_SECOND, 32'h06, 1'b0);
      check("control after store", {29'h0, rd[3:1]}, 32'h2);
      check("irq raised", {31'h0, irq}, 32'h1);
      wr(nvg_pkg::OFS_IRQ_EN, 32'h0);
      rdchk("flag set", nvg_pkg::OFS_IRQ_FLAG, 32'h1 << nvg_pkg::IRQ_DONE);
      check("irq masked", {31'h0, irq}, 32'h0);
      wr(nvg_pkg::OFS_IRQ_EN, 32'h1 << nvg_pkg::IRQ_DONE);
      wr(nvg_pkg::OFS_IRQ_CLR, 32'h1 << nvg_pkg::IRQ_DONE);
      rdchk("flag cleared", nvg_pkg::OFS_IRQ_FLAG, 32'h0);
      check("irq cleared", {31'h0, irq}, 32'h0);
      fetch(a);
      check("stored byte", rd, {24'h0, d});
      mem_a = a;
      mem_d = d;
    end
    $display("Test good stores done");
    for (int i = 0; i < 4; i++) begin
      store(mem_a, ~mem_d, (i == 1) ? nvg_pkg::KEY_SECOND : nvg_pkg::KEY_FIRST,
            (i == 0 || i == 3) ? nvg_pkg::KEY_SECOND : nvg_pkg::KEY_FIRST,
            (i == 0) ? 32'h02 : 32'h06, i == 3);
      check("fault set", {31'h0, rd[3]}, 32'h1);
      rdchk("no completion", nvg_pkg::OFS_IRQ_FLAG, 32'h0);
      fetch(mem_a);
      check("byte kept", rd, {24'h0, mem_d});
    end
    $display("Test refused stores done");
    ext_chk(1'b0, mem_d, 1'b0);
    ext_chk(1'b1, 8'h00, 1'b1);
    // Programmer keeps asking while the CPU reads protected data
    @(posedge ref_clk);
    ext_rd_req <= 1'b1;
    ext_addr <= ~mem_a;
    fetch(mem_a);
    check("cpu read protected", rd, {24'h0, mem_d});
    check("ext data hidden", {24'h0, ext_rdata}, 32'h0);
    ext_rd_req <= 1'b0;
    data_protect_config <= 1'b1;
    $display("Test protection done");
    // Second reset: array keeps its data, timer holds writes off
    reset_dut();
    rdchk("control reset again", nvg_pkg::OFS_CONTROL, 32'h0);
    store(mem_a, ~mem_d, nvg_pkg::KEY_FIRST, nvg_pkg::KEY_SECOND, 32'h06, 1'b0);
    fetch(mem_a);
    check("held by timer", rd, {24'h0, mem_d});
    repeat (60) @(posedge ref_clk);
    store(mem_a, ~mem_d, nvg_pkg::KEY_FIRST, nvg_pkg::KEY_SECOND, 32'h06, 1'b0);
    fetch(mem_a);
    check("store after timer", rd, {24'h0, ~mem_d});
    $display("Test power-up hold done");
    wrap_up();
  end
endmodule : tb_nvg_guard
